// *** verilog/sysopt_pkg.sv ***
// Purpose: constants for the system options register and trigger routing
// Assumes: one 32-bit register on a plain strobe port
// Notes:   offsets are word addresses on the register port
package sysopt_pkg;
    localparam logic [7:0]  OPT_ADDR        = 8'h00;
    localparam int          DELAY_MSB       = 31;
    localparam int          DELAY_LSB       = 24;
    localparam int          ACTIVE_POS      = 23;
    localparam int          BUS_CLOCK_OUT_ENABLE_POS       = 19;
    localparam int          DIV_MSB         = 18;
    localparam int          DIV_LSB         = 16;
    localparam int          TXMOD_POS       = 15;
    localparam int          SYNC_POS        = 14;
    localparam int          RXFILT_POS      = 13;
    localparam int          RXCAP_POS       = 12;
    localparam int          ACIC_POS        = 11;
    localparam int          RTCC_POS        = 10;
    localparam int          SRC_MSB         = 9;
    localparam int          SRC_LSB         = 8;
    localparam logic [31:0] OPT_RESET       = 32'h0000_0000;
    localparam logic [31:0] OPT_WRITE_MASK  = 32'hff0f_bf00;
    localparam logic [1:0]  SRC_RTC         = 2'h0;
    localparam logic [1:0]  SRC_PIT         = 2'h1;
    localparam logic [1:0]  SRC_TIMER_INIT  = 2'h2;
    localparam logic [1:0]  SRC_TIMER_MATCH = 2'h3;
endpackage : sysopt_pkg

// *** verilog/edge_rise.sv ***
// Purpose: two-stage pin synchroniser with rising-edge pulse
// Assumes: input asynchronous to clk
// Notes:   first stage read only by the second
`timescale 1ns/1ps
module edge_rise (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      level,
    output logic      rise
);
    logic meta;
    logic sync;
    logic prev;
    logic next_meta;
    logic next_sync;
    logic next_prev;

    always_comb
    begin
        next_meta = din;
        next_sync = meta;
        next_prev = sync;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            meta <= next_meta;
            sync <= next_sync;
            prev <= next_prev;
        end
    end

    assign level = sync;
    assign rise  = sync & ~prev;
endmodule : edge_rise

// *** verilog/clk_prescale.sv ***
// Purpose: power-of-two prescaler giving output clock level and tick
// Assumes: sel 0 means undivided
// Notes:   tick is one cycle per divided period
`timescale 1ns/1ps
module clk_prescale (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] sel,
    output logic            tick,
    output logic            div_clk
);
    logic [6:0] cnt;
    logic [6:0] next_cnt;
    logic [6:0] lim;
    logic       dclk;
    logic       next_dclk;

    always_comb
    begin
        lim       = 7'((8'h01 << sel) - 8'h01);
        next_cnt  = (cnt >= lim) ? 7'h00 : 7'(cnt + 7'h01);
        // top bit of the count is a square wave with a period of 2^sel cycles
        next_dclk = (sel == 3'h0) ? 1'b0 : next_cnt[sel - 3'h1];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt  <= 7'h00;
            dclk <= 1'b0;
        end
        else
        begin
            cnt  <= next_cnt;
            dclk <= next_dclk;
        end
    end

    assign tick    = (cnt >= lim);
    // undivided selection passes the clock itself
    assign div_clk = (sel == 3'h0) ? clk : dclk;
endmodule : clk_prescale

// *** verilog/sysopt_regs.sv ***
// Purpose: system options register with delayed timer-to-ADC trigger and pin routing
// Assumes: timer triggers and serial receive/comparator signals are pins, synchronised here; SERIAL_TX is only registered
// Notes:   register read data valid the cycle after RD
// Operation
// (RQ1) Bits 31..24 hold an 8-bit delay from timer trigger to ADC trigger.
// (RQ2) Delay is one-shot: starts on trigger, stops when count equals delay.
// (RQ3) Delay spans 0..255 ticks at the divider-selected clock rate.
// (RQ4) Bit 23 reads high while delay counts, low otherwise.
// (RQ5) Bits 22..20 read zero whatever is written.
// (RQ6) Bit 19 enables bus clock output on the clock output pin.
// (RQ7) Bits 18..16 pick divide by 1,2,4..128 for the clock output.
// (RQ8) Bit 15 modulates serial transmit with first timer channel 0.
// (RQ9) Writing 1 to bit 14 pulses a sync trigger to second timer.
// (RQ10) Bit 13 routes serial receive through the analog comparator.
// (RQ11) Delayed trigger reaches ADC only for source codes 10 and 11.
// (RQ12) At terminal count give one-cycle ADC pulse and drop active flag together.
`timescale 1ns/1ps
module sysopt_regs (
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic        TIMER_INIT_TRIG,
    input  wire logic        TIMER_MATCH_TRIG,
    input  wire logic        RTC_OVERFLOW,
    input  wire logic        PIT_OVERFLOW,
    output logic             ADC_TRIGGER,
    output logic             PWM_SYNC_TRIGGER,
    output logic             CLOCK_OUT,
    output logic             CLOCK_OUT_OE_N,
    input  wire logic        SERIAL_TX,
    input  wire logic        TIMER_CH0,
    output logic             SERIAL_TX_PIN,
    input  wire logic        SERIAL_RX_PIN,
    input  wire logic        COMPARATOR_OUT,
    output logic             SERIAL_RX,
    output logic             RX_CAPTURE_ENABLE,
    output logic             COMPARATOR_CAPTURE_ENABLE,
    output logic             RTC_CAPTURE_ENABLE
);
    logic [31:0] opts;
    logic [31:0] next_opts;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [7:0]  dcount;
    logic [7:0]  next_dcount;
    logic        active;
    logic        next_active;
    logic        adc_pulse;
    logic        next_adc_pulse;
    logic        sync_pulse;
    logic        next_sync_pulse;
    logic        direct_trig;
    logic        next_direct_trig;
    logic        tx_pin;
    logic        next_tx_pin;
    logic        rx_out;
    logic        next_rx_out;
    logic        tick;
    logic        div_clk;
    logic        init_rise;
    logic        match_rise;
    logic        rtc_rise;
    logic        pit_rise;
    logic        ch0_lvl;
    logic        rxp_lvl;
    logic        cmp_lvl;
    logic [7:0]  delay_val;
    logic [1:0]  src;
    logic        timer_rise;
    logic        wr_hit;
    logic        rd_hit;
    logic [7:0]  count_inc;
    logic [2:0]  div_sel;
    logic [31:0] read_word;

    edge_rise u_init (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .din   (TIMER_INIT_TRIG),
        .level (),
        .rise  (init_rise)
    );

    edge_rise u_match (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .din   (TIMER_MATCH_TRIG),
        .level (),
        .rise  (match_rise)
    );

    edge_rise u_rtc (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .din   (RTC_OVERFLOW),
        .level (),
        .rise  (rtc_rise)
    );

    edge_rise u_pit (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .din   (PIT_OVERFLOW),
        .level (),
        .rise  (pit_rise)
    );

    edge_rise u_ch0 (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .din   (TIMER_CH0),
        .level (ch0_lvl),
        .rise  ()
    );

    edge_rise u_rxp (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .din   (SERIAL_RX_PIN),
        .level (rxp_lvl),
        .rise  ()
    );

    edge_rise u_cmp (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .din   (COMPARATOR_OUT),
        .level (cmp_lvl),
        .rise  ()
    );

    clk_prescale u_div (
        .clk     (REF_CLK),
        .rst_n   (RSTN),
        .sel     (div_sel), // [RQ7]
        .tick    (tick),
        .div_clk (div_clk)
    );

    assign delay_val = opts[sysopt_pkg::DELAY_MSB:sysopt_pkg::DELAY_LSB]; // [RQ1]
    assign src       = opts[sysopt_pkg::SRC_MSB:sysopt_pkg::SRC_LSB];
    assign wr_hit    = WR && (ADDR == sysopt_pkg::OPT_ADDR);
    assign rd_hit    = RD && (ADDR == sysopt_pkg::OPT_ADDR);
    assign div_sel   = opts[sysopt_pkg::DIV_MSB:sysopt_pkg::DIV_LSB]; // [RQ7]
    // count after the coming tick; wraps only where the delay is already met
    assign count_inc = 8'(dcount + 8'h01);

    // only the selected timer trigger starts the delay
    always_comb
    begin
        unique case (src)
            sysopt_pkg::SRC_TIMER_INIT:  timer_rise = init_rise;  // [RQ11]
            sysopt_pkg::SRC_TIMER_MATCH: timer_rise = match_rise; // [RQ11]
            default:                     timer_rise = 1'b0;
        endcase
    end

    // register storage; writable fields only, status and reserved bits masked
    always_comb
    begin
        next_opts       = opts;
        next_sync_pulse = 1'b0;
        if (wr_hit)
        begin
            next_opts = WDATA & sysopt_pkg::OPT_WRITE_MASK; // [RQ5]
            next_opts[sysopt_pkg::SYNC_POS] = 1'b0;
            next_sync_pulse = WDATA[sysopt_pkg::SYNC_POS]; // [RQ9]
        end
    end

    // one-shot delay counter
    always_comb
    begin
        next_dcount    = dcount;
        next_active    = active;
        next_adc_pulse = 1'b0;
        if (!active)
        begin
            if (timer_rise)
            begin
                if (delay_val == 8'h00)
                begin
                    next_adc_pulse = 1'b1; // [RQ3]
                end
                else
                begin
                    next_dcount = 8'h00;
                    next_active = 1'b1; // [RQ2] [RQ4]
                end
            end
        end
        else if (tick)
        begin
            if (count_inc == delay_val)
            begin
                next_active    = 1'b0; // [RQ12] [RQ4]
                next_adc_pulse = 1'b1; // [RQ12]
                next_dcount    = 8'h00;
            end
            else
            begin
                next_dcount = count_inc; // [RQ2] [RQ3]
            end
        end
    end

    // undelayed sources and pin routing
    always_comb
    begin
        next_direct_trig = 1'b0;
        unique case (src)
            sysopt_pkg::SRC_RTC: next_direct_trig = rtc_rise;
            sysopt_pkg::SRC_PIT: next_direct_trig = pit_rise;
            default:             next_direct_trig = 1'b0;
        endcase
        next_tx_pin = opts[sysopt_pkg::TXMOD_POS] ? (SERIAL_TX & ch0_lvl) : SERIAL_TX; // [RQ8]
        next_rx_out = opts[sysopt_pkg::RXFILT_POS] ? cmp_lvl : rxp_lvl; // [RQ10]
    end

    // read word assembled field by field; reserved bits and the sync bit stay zero
    always_comb
    begin
        read_word = 32'h0000_0000; // [RQ5]
        read_word[sysopt_pkg::DELAY_MSB:sysopt_pkg::DELAY_LSB] = delay_val; // [RQ1]
        read_word[sysopt_pkg::ACTIVE_POS] = active; // [RQ4]
        read_word[sysopt_pkg::BUS_CLOCK_OUT_ENABLE_POS] = opts[sysopt_pkg::BUS_CLOCK_OUT_ENABLE_POS];
        read_word[sysopt_pkg::DIV_MSB:sysopt_pkg::DIV_LSB] = div_sel;
        read_word[sysopt_pkg::TXMOD_POS] = opts[sysopt_pkg::TXMOD_POS];
        read_word[sysopt_pkg::RXFILT_POS] = opts[sysopt_pkg::RXFILT_POS];
        read_word[sysopt_pkg::RXCAP_POS] = opts[sysopt_pkg::RXCAP_POS];
        read_word[sysopt_pkg::ACIC_POS] = opts[sysopt_pkg::ACIC_POS];
        read_word[sysopt_pkg::RTCC_POS] = opts[sysopt_pkg::RTCC_POS];
        read_word[sysopt_pkg::SRC_MSB:sysopt_pkg::SRC_LSB] = src;
    end

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (rd_hit)
        begin
            next_rdata = read_word;
        end
    end

    // register word, read data and sync strobe
    always_ff @(posedge REF_CLK)
    begin
        if (!RSTN)
        begin
            opts       <= sysopt_pkg::OPT_RESET;
            rdata      <= 32'h0000_0000;
            sync_pulse <= 1'b0;
        end
        else
        begin
            opts       <= next_opts;
            rdata      <= next_rdata;
            sync_pulse <= next_sync_pulse;
        end
    end

    // delay counter and ADC trigger
    always_ff @(posedge REF_CLK)
    begin
        if (!RSTN)
        begin
            dcount      <= 8'h00;
            active      <= 1'b0;
            adc_pulse   <= 1'b0;
            direct_trig <= 1'b0;
        end
        else
        begin
            dcount      <= next_dcount;
            active      <= next_active;
            adc_pulse   <= next_adc_pulse;
            direct_trig <= next_direct_trig;
        end
    end

    // pin routing registers; serial lines idle high
    always_ff @(posedge REF_CLK)
    begin
        if (!RSTN)
        begin
            tx_pin <= 1'b1;
            rx_out <= 1'b1;
        end
        else
        begin
            tx_pin <= next_tx_pin;
            rx_out <= next_rx_out;
        end
    end

    assign RDATA                     = rdata;
    assign ADC_TRIGGER               = adc_pulse | direct_trig; // [RQ11]
    assign PWM_SYNC_TRIGGER          = sync_pulse;
    assign CLOCK_OUT                 = opts[sysopt_pkg::BUS_CLOCK_OUT_ENABLE_POS] ? div_clk : 1'b0; // [RQ6]
    assign CLOCK_OUT_OE_N            = ~opts[sysopt_pkg::BUS_CLOCK_OUT_ENABLE_POS]; // [RQ6]
    assign SERIAL_TX_PIN             = tx_pin;
    assign SERIAL_RX                 = rx_out;
    assign RX_CAPTURE_ENABLE         = opts[sysopt_pkg::RXCAP_POS];
    assign COMPARATOR_CAPTURE_ENABLE = opts[sysopt_pkg::ACIC_POS];
    assign RTC_CAPTURE_ENABLE        = opts[sysopt_pkg::RTCC_POS];
endmodule : sysopt_regs

// *** test/timer_peer.sv ***
// Purpose: far-side timer trigger model
// Assumes: fire is a one-cycle request per trigger line
// Notes:   a trigger stands 3 cycles so the synchroniser sees it
`timescale 1ns/1ps
module timer_peer (
    input  wire logic       clk,
    input  wire logic [3:0] fire,
    output logic      [3:0] trig
);
    logic [3:0] d1 = 4'h0;
    logic [3:0] d2 = 4'h0;
    logic [3:0] d3 = 4'h0;
    always @(posedge clk)
    begin
        d1 <= fire;
        d2 <= d1;
        d3 <= d2;
    end
    assign trig = d1 | d2 | d3;
endmodule : timer_peer

// *** test/sysopt_regs_sva.sv ***
// Purpose: port checks for the system options block
// Assumes: shadow copy follows writes to word 0
// Notes:   bound to sysopt_regs
`timescale 1ns/1ps
module sysopt_regs_sva (
    input wire logic        REF_CLK,
    input wire logic        RSTN,
    input wire logic [7:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic        ADC_TRIGGER,
    input wire logic        PWM_SYNC_TRIGGER,
    input wire logic        CLOCK_OUT,
    input wire logic        CLOCK_OUT_OE_N,
    input wire logic        SERIAL_TX,
    input wire logic        SERIAL_TX_PIN
);
    localparam logic [31:0] M = sysopt_pkg::OPT_WRITE_MASK;
    logic [31:0] sh;
    logic        wr0;
    assign wr0 = WR && ADDR == sysopt_pkg::OPT_ADDR;
    always_ff @(posedge REF_CLK)
        sh <= !RSTN ? 32'h0 : (wr0 ? WDATA & M : sh);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    chk_oe_level: assert property (CLOCK_OUT_OE_N == !sh[19])
        else $error("output enable wrong");
    chk_clk_off: assert property (!sh[19] |-> !CLOCK_OUT)
        else $error("clock out not idle");
    chk_sync_set: assert property (wr0 && WDATA[14] |=> PWM_SYNC_TRIGGER)
        else $error("sync pulse missing");
    chk_sync_cause: assert property (PWM_SYNC_TRIGGER |-> $past(wr0 && WDATA[14]))
        else $error("sync pulse unasked");
    chk_rsvd_zero: assert property (RDATA[22:20] == 3'h0 && !RDATA[14])
        else $error("reserved bits set");
    chk_rd_data: assert property ($past(RD && ADDR == sysopt_pkg::OPT_ADDR)
        |-> (RDATA & M) == ($past(sh) & M))
        else $error("read data wrong");
    chk_tx_direct: assert property ($past(!sh[15]) |-> SERIAL_TX_PIN == $past(SERIAL_TX))
        else $error("tx not direct");
    chk_adc_single: assert property (ADC_TRIGGER |=> !ADC_TRIGGER)
        else $error("adc pulse too long");
    cover property (ADC_TRIGGER);
    cover property (PWM_SYNC_TRIGGER);
    cover property (RD ##1 RDATA[23]);
endmodule : sysopt_regs_sva
bind sysopt_regs sysopt_regs_sva i_chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .ADC_TRIGGER(ADC_TRIGGER),
    .PWM_SYNC_TRIGGER(PWM_SYNC_TRIGGER), .CLOCK_OUT(CLOCK_OUT),
    .CLOCK_OUT_OE_N(CLOCK_OUT_OE_N), .SERIAL_TX(SERIAL_TX), .SERIAL_TX_PIN(SERIAL_TX_PIN));

// *** test/system_options_trigger_routing_tb.sv ***
// Purpose: register, trigger delay and pin routing tests
// Assumes: timer_peer drives the timer trigger pins
// Notes:   delays measured against a zero-delay run
`timescale 1ns/1ps
module system_options_trigger_routing_tb;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        tx = 1'b1;
    logic        rxp = 1'b0;
    logic        ch0 = 1'b0;
    logic        cmp = 1'b1;
    logic [3:0]  fire = 4'h0;
    logic [3:0]  trig;
    logic [31:0] rdata;
    logic [31:0] q;
    logic        adc, sync, clko, oen, txp, sx, prev;
    int          fails = 0;
    int          tests_run = 0;
    int          n, base, cnt;
    logic [31:0] cfg [5] = '{32'h0000_0200, 32'h0300_0200, 32'h0300_0300,
                             32'hff00_0200, 32'h0302_0200};
    int          lo [5] = '{0, 3, 3, 255, 8};
    int          hi [5] = '{0, 3, 3, 255, 13};
    always #10 clk = ~clk;
    timer_peer i_peer (.clk(clk), .fire(fire), .trig(trig));
    sysopt_regs i_dut (.REF_CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .TIMER_INIT_TRIG(trig[0]), .TIMER_MATCH_TRIG(trig[1]),
        .RTC_OVERFLOW(trig[2]), .PIT_OVERFLOW(trig[3]), .ADC_TRIGGER(adc),
        .PWM_SYNC_TRIGGER(sync), .CLOCK_OUT(clko), .CLOCK_OUT_OE_N(oen), .SERIAL_TX(tx),
        .TIMER_CH0(ch0), .SERIAL_TX_PIN(txp), .SERIAL_RX_PIN(rxp), .COMPARATOR_OUT(cmp),
        .SERIAL_RX(sx), .RX_CAPTURE_ENABLE(), .COMPARATOR_CAPTURE_ENABLE(),
        .RTC_CAPTURE_ENABLE());
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    task automatic pulse(input logic [3:0] f);
        @(posedge clk);
        fire <= f;
        @(posedge clk);
        fire <= 4'h0;
    endtask : pulse
    task automatic wait_adc(output int k);
        #1;
        k = 0;
        while (adc !== 1'b1 && k < 300)
        begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask : wait_adc
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    initial
    begin
        #(20 * 40000);
        fails++;
        test_done();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(8'h00, q);
        check(q, 32'h0);
        wr_reg(8'h00, 32'hffff_ffff);
        wr_reg(8'h04, 32'h0);
        rd_reg(8'h04, q);
        check(q, 32'h0);
        rd_reg(8'h00, q);
        check(q, 32'hff0f_bf00);
        $display("register test done");
        for (int i = 0; i < 5; i++)
        begin
            wr_reg(8'h00, cfg[i]);
            pulse(cfg[i][8] ? 4'h2 : 4'h1);
            wait_adc(n);
            if (i == 0)
                base = n;
            check(n - base >= lo[i] && n - base <= hi[i], 1'b1);
        end
        pulse(4'h1);
        repeat (10) @(posedge clk);
        rd_reg(8'h00, q);
        check(q[23], 1'b1);
        wait_adc(n);
        rd_reg(8'h00, q);
        check(q[23], 1'b0);
        for (int s = 0; s < 2; s++)
        begin
            wr_reg(8'h00, 32'h0a00_0000 | (s << 8));
            pulse(4'h3);
            wait_adc(n);
            check(n, 300);
            pulse(s ? 4'h8 : 4'h4);
            wait_adc(n);
            check(n <= base, 1'b1);
        end
        $display("delay test done");
        wr_reg(8'h00, 32'h0000_4000);
        #1;
        check(sync, 1'b1);
        wr_reg(8'h00, 32'h0008_0000);
        #5;
        check({sync, oen, clko}, 3'h1);
        #10;
        check(clko, 1'b0);
        for (int s = 1; s < 8; s++)
        begin
            wr_reg(8'h00, 32'h0008_0000 | (s << 16));
            #1;
            cnt = 0;
            prev = clko;
            repeat (256)
            begin
                @(posedge clk);
                #1;
                cnt += (clko !== prev);
                prev = clko;
            end
            check(cnt >= (512 >> s) - 2 && cnt <= (512 >> s) + 2, 1'b1);
        end
        wr_reg(8'h00, 32'h0);
        repeat (6) @(posedge clk);
        #1;
        check({oen, clko, txp, sx}, 4'ha);
        @(posedge clk);
        tx <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(txp, 1'b0);
        @(posedge clk);
        tx <= 1'b1;
        wr_reg(8'h00, 32'h0000_a000);
        repeat (6) @(posedge clk);
        #1;
        check({txp, sx}, 2'h1);
        @(posedge clk);
        ch0 <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        check(txp, 1'b1);
        $display("routing test done");
        test_done();
    end
endmodule : system_options_trigger_routing_tb
